// File: relay_output_defs.svh
`ifndef RELAY_OUTPUT_DEFS_SVH
`define RELAY_OUTPUT_DEFS_SVH

// ----------------------------------------
// Widths
// ----------------------------------------
`define RLY_SEL_W 4
`define RLY_VAL_W 16
`define RLY_CW_W 16

// ----------------------------------------
// Function settings and field positions
// ----------------------------------------
`define RLY_SEL_AT_SPEED 4'h2
`define RLY_SEL_FAULT 4'h3
`define RLY_SEL_FREQ_GE 4'h4
`define RLY_SEL_CURR_GE 4'h5
`define RLY_SEL_FREQ_LT 4'h6
`define RLY_SEL_CURR_LT 4'h7
`define RLY_SEL_AIN2_GT 4'h8
`define RLY_SEL_READY 4'h9
`define RLY_SEL_OVERRIDE 4'ha
`define RLY_SEL_FREQ_HOLD 4'hb
`define RLY_SEL_FIELDBUS 4'hc
`define RLY_CW_RELAY_BIT 8
`define RLY_OUT_RESET 1'h0

`endif

// File: relay_output_pkg.sv
`default_nettype none
package relay_output_pkg;
  `include "relay_output_defs.svh"

  typedef logic [`RLY_SEL_W-1:0] sel_t;
  typedef logic [`RLY_VAL_W-1:0] value_t;
  typedef logic [`RLY_CW_W-1:0] ctrl_word_t;
endpackage
`default_nettype wire

// File: relay_threshold_cmp.sv
`timescale 1ns/1ps
`default_nettype none

module relay_threshold_cmp
  import relay_output_pkg::*;
(
  // Operands
  input wire relay_output_pkg::value_t freqVal,
  input wire relay_output_pkg::value_t currVal,
  input wire relay_output_pkg::value_t ain2Val,
  input wire relay_output_pkg::value_t threshold,
  // Comparison results
  output logic freqGe,
  output logic currGe,
  output logic ain2Gt
);

  // ----------------------------------------
  // Comparators against the one shared limit
  // ----------------------------------------
  assign freqGe = (freqVal >= threshold);
  assign currGe = (currVal >= threshold);
  assign ain2Gt = (ain2Val > threshold);

endmodule

`default_nettype wire

// File: relay_output_select.sv
`timescale 1ns/1ps
`default_nettype none
`include "relay_output_defs.svh"


module relay_output_select
  import relay_output_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Configuration
  input wire relay_output_pkg::sel_t funcSel,
  input wire relay_output_pkg::value_t thresholdLevel,
  // Measurements
  input wire relay_output_pkg::value_t outFreq,
  input wire relay_output_pkg::value_t motorCurrent,
  input wire relay_output_pkg::value_t analogIn2,
  // Drive status
  input wire logic atTargetFreq,
  input wire logic driveFault,
  input wire logic readyToRun,
  input wire logic overrideActive,
  input wire relay_output_pkg::ctrl_word_t fieldbusCtrlWord,
  // Relay contact
  output logic relayOut
);

  // ----------------------------------------
  // Threshold comparisons
  // ----------------------------------------
  logic freqGe;
  logic currGe;
  logic ain2Gt;
  logic relayOut_ff;
  logic nxt_relayOut;

  // One comparator set shared by every threshold setting
  relay_threshold_cmp u_cmp (
    .freqVal(outFreq),
    .currVal(motorCurrent),
    .ain2Val(analogIn2),
    .threshold(thresholdLevel),
    .freqGe(freqGe),
    .currGe(currGe),
    .ain2Gt(ain2Gt)
  );

  // ----------------------------------------
  // Source selection
  // ----------------------------------------
  // Decode of each function setting
  wire selAtSpeed = (funcSel == `RLY_SEL_AT_SPEED);
  wire selFault = (funcSel == `RLY_SEL_FAULT);
  wire selFreqGe = (funcSel == `RLY_SEL_FREQ_GE);
  wire selCurrGe = (funcSel == `RLY_SEL_CURR_GE);
  wire selFreqLt = (funcSel == `RLY_SEL_FREQ_LT);
  wire selCurrLt = (funcSel == `RLY_SEL_CURR_LT);
  wire selAin2 = (funcSel == `RLY_SEL_AIN2_GT);
  wire selReady = (funcSel == `RLY_SEL_READY);
  wire selOverride = (funcSel == `RLY_SEL_OVERRIDE);
  wire selFreqHold = (funcSel == `RLY_SEL_FREQ_HOLD);
  wire selFieldbus = (funcSel == `RLY_SEL_FIELDBUS);

  // Control word bit that commands the relay
  wire fbBit = fieldbusCtrlWord[`RLY_CW_RELAY_BIT];

  // Hold only while override is active in setting 11
  wire holdNow = selFreqHold & overrideActive;

  // Unlisted settings drive the relay low
  assign nxt_relayOut = holdNow ? relayOut_ff :
    (selAtSpeed & atTargetFreq) |
    (selFault & driveFault) |
    (selFreqGe & freqGe) |
    (selCurrGe & currGe) |
    (selFreqLt & ~freqGe) |
    (selCurrLt & ~currGe) |
    (selAin2 & ain2Gt) |
    (selReady & readyToRun & ~driveFault) |
    (selOverride & overrideActive) |
    (selFreqHold & freqGe) |
    (selFieldbus & fbBit);

  // ----------------------------------------
  // Output register
  // ----------------------------------------
  // Relay state updated every clock
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      relayOut_ff <= `RLY_OUT_RESET;
    end else begin
      relayOut_ff <= nxt_relayOut;
    end
  end

  // Contact drive straight from the register
  assign relayOut = relayOut_ff;

  // ----------------------------------------
  // Checks on threshold settings
  // ----------------------------------------
  // Setting 4 follows frequency against limit
  property p_freq_ge;
    @(posedge clock) disable iff (!reset_n)
      (funcSel == `RLY_SEL_FREQ_GE) |=> (relayOut == $past(outFreq >= thresholdLevel));
  endproperty
  a_freq_ge: assert property (p_freq_ge) else $error("freq >= limit mismatch");

  // Setting 5 follows current against limit
  property p_curr_ge;
    @(posedge clock) disable iff (!reset_n)
      (funcSel == `RLY_SEL_CURR_GE) |=> (relayOut == $past(motorCurrent >= thresholdLevel));
  endproperty
  a_curr_ge: assert property (p_curr_ge) else $error("current >= limit mismatch");

  // Setting 6 on below limit
  property p_freq_lt;
    @(posedge clock) disable iff (!reset_n)
      (funcSel == `RLY_SEL_FREQ_LT) && (outFreq < thresholdLevel) |=> relayOut;
  endproperty
  a_freq_lt: assert property (p_freq_lt) else $error("freq < limit not seen");

  // Setting 6 off at or above limit
  property p_freq_lt_off;
    @(posedge clock) disable iff (!reset_n)
      (funcSel == `RLY_SEL_FREQ_LT) && (outFreq >= thresholdLevel) |=> !relayOut;
  endproperty
  a_freq_lt_off: assert property (p_freq_lt_off) else $error("freq < relay on at limit");

  // Setting 7 follows current below limit
  property p_curr_lt;
    @(posedge clock) disable iff (!reset_n)
      (funcSel == `RLY_SEL_CURR_LT) |=> (relayOut == $past(motorCurrent < thresholdLevel));
  endproperty
  a_curr_lt: assert property (p_curr_lt) else $error("current < limit mismatch");

  // Setting 8 follows input 2 above limit
  property p_ain2;
    @(posedge clock) disable iff (!reset_n)
      (funcSel == `RLY_SEL_AIN2_GT) |=> (relayOut == $past(analogIn2 > thresholdLevel));
  endproperty
  a_ain2: assert property (p_ain2) else $error("input 2 > limit mismatch");

  // ----------------------------------------
  // Checks on status settings
  // ----------------------------------------
  // Setting 9 off while tripped
  property p_ready;
    @(posedge clock) disable iff (!reset_n)
      (funcSel == `RLY_SEL_READY) && driveFault |=> !relayOut;
  endproperty
  a_ready: assert property (p_ready) else $error("ready relay on while tripped");

  // Setting 9 on when ready and untripped
  property p_ready_on;
    @(posedge clock) disable iff (!reset_n)
      (funcSel == `RLY_SEL_READY) && readyToRun && !driveFault |=> relayOut;
  endproperty
  a_ready_on: assert property (p_ready_on) else $error("ready relay off while ready");

  // Setting 10 follows override mode
  property p_override;
    @(posedge clock) disable iff (!reset_n)
      (funcSel == `RLY_SEL_OVERRIDE) |=> (relayOut == $past(overrideActive));
  endproperty
  a_override: assert property (p_override) else $error("override relay mismatch");

  // Setting 11 frozen during override
  property p_hold;
    @(posedge clock) disable iff (!reset_n)
      (funcSel == `RLY_SEL_FREQ_HOLD) && overrideActive |=> $stable(relayOut);
  endproperty
  a_hold: assert property (p_hold) else $error("relay changed during override");

  // Setting 11 tracks frequency outside override
  property p_hold_follow;
    @(posedge clock) disable iff (!reset_n)
      (funcSel == `RLY_SEL_FREQ_HOLD) && !overrideActive
        |=> (relayOut == $past(outFreq >= thresholdLevel));
  endproperty
  a_hold_follow: assert property (p_hold_follow) else $error("setting 11 tracking mismatch");

  // Setting 12 follows control word bit
  property p_fieldbus;
    @(posedge clock) disable iff (!reset_n)
      (funcSel == `RLY_SEL_FIELDBUS)
        |=> (relayOut == $past(fieldbusCtrlWord[`RLY_CW_RELAY_BIT]));
  endproperty
  a_fieldbus: assert property (p_fieldbus) else $error("fieldbus bit not followed");

  // Setting 3 follows fault state
  property p_fault;
    @(posedge clock) disable iff (!reset_n)
      (funcSel == `RLY_SEL_FAULT) |=> (relayOut == $past(driveFault));
  endproperty
  a_fault: assert property (p_fault) else $error("fault relay mismatch");

  // Setting 2 follows at-speed state
  property p_at_speed;
    @(posedge clock) disable iff (!reset_n)
      (funcSel == `RLY_SEL_AT_SPEED) |=> (relayOut == $past(atTargetFreq));
  endproperty
  a_at_speed: assert property (p_at_speed) else $error("at-speed relay mismatch");

  // Unlisted settings keep the relay off
  property p_unlisted;
    @(posedge clock) disable iff (!reset_n)
      (funcSel < `RLY_SEL_AT_SPEED) || (funcSel > `RLY_SEL_FIELDBUS) |=> !relayOut;
  endproperty
  a_unlisted: assert property (p_unlisted) else $error("unlisted setting drove relay");

  // Register held off while reset is low
  property p_reset_low;
    @(posedge clock)
      !reset_n |=> !relayOut;
  endproperty
  a_reset_low: assert property (p_reset_low) else $error("relay on during reset");

endmodule

`default_nettype wire

// File: relay_far_side.sv
`timescale 1ns/1ps
`default_nettype none
// Fieldbus controller that commands the relay, and the relay contact itself
module relay_far_side
  import relay_output_pkg::*;
(
  // Clock
  input wire logic clock,
  // Bench command
  input wire logic cmdRelay,
  // Relay side
  input wire logic relayOut,
  output var relay_output_pkg::ctrl_word_t fieldbusCtrlWord,
  output logic contactClosed
);
  logic [15:0] churn = 16'h0000;
  // Bit 8 carries the command, the other bits churn every cycle
  always @(posedge clock) begin
    churn <= churn + 16'h0101;
    fieldbusCtrlWord <= {churn[15:9], cmdRelay, churn[7:0]};
  end
  // Contact follows the coil drive
  assign contactClosed = relayOut;
endmodule
`default_nettype wire

// File: test_relay_output_select.sv
`timescale 1ns/1ps
`default_nettype none
module test_relay_output_select;
  import relay_output_pkg::*;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  sel_t funcSel = 4'h0;
  value_t thresholdLevel = 16'h0064;
  value_t outFreq = 16'h0000;
  value_t motorCurrent = 16'h0000;
  value_t analogIn2 = 16'h0000;
  logic [3:0] st = 4'h0;
  logic cmdRelay = 1'b0;
  ctrl_word_t fieldbusCtrlWord;
  logic relayOut;
  logic contactClosed;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cycles = 0;
  // ----------------------------------------
  // Clock, design and far side
  // ----------------------------------------
  always #25 clock = ~clock;
  relay_output_select u_dut (.clock(clock), .reset_n(reset_n), .funcSel(funcSel),
    .thresholdLevel(thresholdLevel), .outFreq(outFreq), .motorCurrent(motorCurrent),
    .analogIn2(analogIn2), .atTargetFreq(st[3]), .driveFault(st[2]), .readyToRun(st[1]),
    .overrideActive(st[0]), .fieldbusCtrlWord(fieldbusCtrlWord), .relayOut(relayOut));
  relay_far_side u_far (.clock(clock), .cmdRelay(cmdRelay), .relayOut(relayOut),
    .fieldbusCtrlWord(fieldbusCtrlWord), .contactClosed(contactClosed));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic e, input string what);
    samples_checked++;
    if (relayOut !== e || contactClosed !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %b seen %b", what, e, relayOut);
    end
  endtask
  // Apply inputs at one edge, settle after the next
  task automatic put(input sel_t s, input value_t f, c, a, input logic [3:0] b);
    @(posedge clock);
    funcSel <= s;
    outFreq <= f;
    motorCurrent <= c;
    analogIn2 <= a;
    st <= b;
    @(posedge clock);
    #1;
  endtask
  task automatic end_of_test();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_cmp();
    value_t v;
    value_t o;
    for (int s = 4; s <= 8; s++) begin
      for (int d = -1; d <= 1; d++) begin
        v = value_t'(100 + d);
        o = (d >= 0) ? 16'h0000 : 16'hffff;
        put(sel_t'(s), (s == 4 || s == 6) ? v : o, (s == 5 || s == 7) ? v : o,
          (s == 8) ? v : o, 4'h2);
        chk((s == 8) ? d > 0 : (s < 6) ? d >= 0 : d < 0, "threshold");
      end
    end
    $display("test threshold done");
  endtask
  task automatic t_status();
    put(4'h9, 0, 0, 0, 4'h2);
    chk(1'b1, "ready");
    put(4'h9, 0, 0, 0, 4'h6);
    chk(1'b0, "ready tripped");
    put(4'ha, 0, 0, 0, 4'h1);
    chk(1'b1, "override");
    put(4'ha, 0, 0, 0, 4'he);
    chk(1'b0, "override off");
    put(4'h2, 0, 0, 0, 4'h8);
    chk(1'b1, "at speed");
    put(4'h2, 0, 0, 0, 4'h7);
    chk(1'b0, "not at speed");
    put(4'h3, 0, 0, 0, 4'h4);
    chk(1'b1, "fault");
    put(4'h3, 0, 0, 0, 4'hb);
    chk(1'b0, "no fault");
    for (int s = 0; s < 16; s++) begin
      if (s < 2 || s > 12) begin
        put(sel_t'(s), 16'hffff, 16'hffff, 16'hffff, 4'hf);
        chk(1'b0, "unlisted");
      end
    end
    $display("test status done");
  endtask
  task automatic t_hold();
    put(4'hb, 16'h00c8, 0, 0, 4'h0);
    chk(1'b1, "hold on");
    put(4'hb, 16'h0000, 0, 0, 4'h1);
    chk(1'b1, "hold frozen high");
    put(4'hb, 16'h0000, 0, 0, 4'h0);
    chk(1'b0, "hold off");
    put(4'hb, 16'h0064, 0, 0, 4'h1);
    chk(1'b0, "hold frozen low");
    put(4'hb, 16'h0064, 0, 0, 4'h0);
    chk(1'b1, "hold resumed");
    $display("test hold done");
  endtask
  task automatic t_bus();
    for (int k = 1; k >= 0; k--) begin
      @(posedge clock);
      cmdRelay <= k[0];
      put(4'hc, 0, 0, 0, 4'h0);
      chk(k[0], "fieldbus");
    end
    $display("test fieldbus done");
  endtask
  task automatic t_reset();
    put(4'ha, 0, 0, 0, 4'h1);
    chk(1'b1, "override before reset");
    @(posedge clock);
    reset_n <= 1'b0;
    #1;
    chk(1'b0, "reset");
    @(posedge clock);
    reset_n <= 1'b1;
    funcSel <= 4'ha;
    st <= 4'h1;
    #1;
    chk(1'b0, "before edge");
    @(posedge clock);
    #1;
    chk(1'b1, "after edge");
    $display("test reset done");
  endtask
  // ----------------------------------------
  // Main sequence and timeout
  // ----------------------------------------
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  initial begin
    repeat (20) @(posedge clock);
    reset_n <= 1'b1;
    t_cmp();
    t_status();
    t_hold();
    t_bus();
    t_reset();
    end_of_test();
  end
endmodule
`default_nettype wire
